/* rtl/rtk_pkg.sv */
/*
  rtk_pkg: shared constants, carriers and state encodings for the
  timekeeping core (APB register slave plus BCD calendar counters).
  Assumes a single 40 MHz pclk domain and an 8-bit APB byte address.
*/
package rtk_pkg;

	// bus geometry: one aligned 32-bit word per register, index at paddr[6:2]
	localparam int PADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int REG_W = 8;
	localparam int IDX_W = 5;
	localparam int IDX_LSB = 2;

	typedef logic [REG_W-1:0] rtk_bcd_t;
	typedef logic [IDX_W-1:0] rtk_idx_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [PADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} rtk_apb_req_t;

	typedef struct packed {
		logic pready;
		logic [DATA_W-1:0] prdata;
		logic pslverr;
	} rtk_apb_rsp_t;

	// register indices; byte address is four times the index
	localparam rtk_idx_t IDX_SEC = 5'h00;
	localparam rtk_idx_t IDX_MIN = 5'h01;
	localparam rtk_idx_t IDX_HOUR = 5'h02;
	localparam rtk_idx_t IDX_DAY_OF_WEEK = 5'h03;
	localparam rtk_idx_t IDX_DATE = 5'h04;
	localparam rtk_idx_t IDX_MONTH = 5'h05;
	localparam rtk_idx_t IDX_YEAR = 5'h06;
	localparam rtk_idx_t IDX_CTRL = 5'h07;
	localparam rtk_idx_t IDX_LAST = 5'h1f;

	// field positions
	localparam int SEC_START_BIT = 7;
	localparam int HR_FMT_BIT = 6;
	localparam int HR_PM_BIT = 5;
	localparam int WKD_RUN_BIT = 5;
	localparam int MTH_LEAP_BIT = 5;
	localparam int CTRL_EXT_BIT = 3;

	// writable masks and digit masks
	localparam rtk_bcd_t SEC_WR_MASK = 8'hff;
	localparam rtk_bcd_t SEC_DIGIT_MASK = 8'h7f;
	localparam rtk_bcd_t MIN_MASK = 8'h7f;
	localparam rtk_bcd_t HR_WR_MASK = 8'h7f;
	localparam rtk_bcd_t HR24_MASK = 8'h3f;
	localparam rtk_bcd_t HR12_MASK = 8'h1f;
	localparam rtk_bcd_t WKD_WR_MASK = 8'h1f;
	localparam rtk_bcd_t WKD_DAY_MASK = 8'h07;
	localparam rtk_bcd_t DATE_MASK = 8'h3f;
	localparam rtk_bcd_t MTH_MASK = 8'h1f;
	localparam rtk_bcd_t YEAR_MASK = 8'hff;
	localparam rtk_bcd_t CTRL_WR_MASK = 8'hff;

	// bcd limits
	localparam logic [3:0] BCD_ONES_MAX = 4'h9;
	localparam logic [3:0] BCD_NIB_ONE = 4'h1;
	localparam logic [3:0] BCD_NIB_ZERO = 4'h0;
	localparam rtk_bcd_t BCD_00 = 8'h00;
	localparam rtk_bcd_t BCD_01 = 8'h01;
	localparam rtk_bcd_t BCD_07 = 8'h07;
	localparam rtk_bcd_t BCD_11 = 8'h11;
	localparam rtk_bcd_t BCD_12 = 8'h12;
	localparam rtk_bcd_t BCD_23 = 8'h23;
	localparam rtk_bcd_t BCD_28 = 8'h28;
	localparam rtk_bcd_t BCD_29 = 8'h29;
	localparam rtk_bcd_t BCD_30 = 8'h30;
	localparam rtk_bcd_t BCD_31 = 8'h31;
	localparam rtk_bcd_t BCD_59 = 8'h59;
	localparam rtk_bcd_t BCD_99 = 8'h99;
	localparam rtk_bcd_t MTH_FEB = 8'h02;
	localparam rtk_bcd_t MTH_APR = 8'h04;
	localparam rtk_bcd_t MTH_JUN = 8'h06;
	localparam rtk_bcd_t MTH_SEP = 8'h09;
	localparam rtk_bcd_t MTH_NOV = 8'h11;

	// oscillator supervision and one-second divider
	localparam int EDGE_W = 6;
	localparam logic [EDGE_W-1:0] START_EDGES = 6'h20;
	localparam logic [EDGE_W-1:0] EDGE_ONE = 6'h01;
	localparam int DIV_W = 15;
	localparam logic [DIV_W-1:0] DIV_LAST = 15'h7fff;
	localparam logic [DIV_W-1:0] DIV_ONE = 15'h0001;
	localparam int PCLK_HZ = 40_000_000;
	localparam int HZ_PER_MHZ = 1_000_000;
	localparam int OSC_FAIL_TIMEOUT_US = 200;
	localparam int OSC_FAIL_CYC_DEF = OSC_FAIL_TIMEOUT_US * (PCLK_HZ / HZ_PER_MHZ);
	localparam int IDLE_W = 16;
	localparam logic [IDLE_W-1:0] IDLE_ONE = 16'h0001;
	localparam logic [IDX_W-1:0] IDX_ONE = 5'h01;

	typedef enum logic [2:0] {
		OSC_STOPPED = 3'b001,
		OSC_STARTING = 3'b010,
		OSC_RUNNING = 3'b100
	} rtk_osc_t;

	typedef struct packed {
		rtk_bcd_t sec;
		rtk_bcd_t min;
		rtk_bcd_t hour;
		rtk_bcd_t day_of_week;
		rtk_bcd_t date;
		rtk_bcd_t month;
		rtk_bcd_t year;
	} rtk_time_t;

	localparam rtk_time_t TIME_RST = '{
		sec: 8'h00, min: 8'h00, hour: 8'h00, day_of_week: 8'h01,
		date: 8'h01, month: 8'h01, year: 8'h00
	};
	localparam rtk_bcd_t CTRL_RST = 8'h00;

endpackage

/* rtl/rtk_bcd_step.sv */
/*
  rtk_bcd_step: one packed-BCD counter stage, advancing by one and wrapping
  from a last value to a first value. Pure combinational.
  Assumes cur holds a valid BCD value within [first, last].
*/
`timescale 1ns/1ps
`default_nettype none

module rtk_bcd_step (
	input wire rtk_pkg::rtk_bcd_t cur,
	input wire rtk_pkg::rtk_bcd_t first,
	input wire rtk_pkg::rtk_bcd_t last,
	input wire logic inc,
	output rtk_pkg::rtk_bcd_t nxt,
	output logic wrap
);
	import rtk_pkg::*;

	// wrap at last, otherwise a decimal increment with carry into the tens digit
	always_comb
	begin
		nxt = cur;
		wrap = 1'b0;
		if (inc)
		begin
			if (cur == last)
			begin
				nxt = first;
				wrap = 1'b1;
			end
			else if (cur[3:0] >= BCD_ONES_MAX)
				nxt = {cur[7:4] + BCD_NIB_ONE, BCD_NIB_ZERO};
			else
				nxt = {cur[7:4], cur[3:0] + BCD_NIB_ONE};
		end
	end

endmodule
`default_nettype wire

/* rtl/rtk_core.sv */
/*
  rtk_core: timekeeping core of a real-time clock calendar, with an APB
  register slave, oscillator start/running supervision, a 32768:1 second
  divider, BCD calendar counters and a coherent read snapshot.
  Assumes osc_in_pin is synchronous to pclk and much slower than it, and
  that the whole block sits on the always-on (backup) supply.

// How it works
// - external clock on input pin counts only while ext_clock_enable is set.
// - bit 7 of seconds starts the crystal oscillator; powers up as 0.
// - osc_running_flag sets after 32 oscillator cycles from start.
// - osc_running_flag clears after no oscillator cycle for the fail timeout.
// - separate seconds..year registers; year is two BCD digits.
// - short months handled; leap year every fourth two-digit year.
// - 12-hour and 24-hour formats, chosen by the format bit.
// - weekday counts 1 to 7, steps at midnight, values carry no meaning.
// - all time and date values held as packed BCD.
// - counting continues on backup supply, no stop for supply change.
// - a fresh read operation copies live counters into a read buffer.
// - read buffer refreshed again when sequential address wraps 0x1F to 0x00.
// - 11:59:59 PM to 12:00:00 AM, or 23:59:59 to 00:00:00, carries day.
// - weekday wraps 7 to 1 without carry.
// - month lengths 31/30, February 29 in leap years else 28.
// - 12/31 advances to 01/01 and carries into year.
// - year wraps 99 to 00 with no further carry.
// - seconds tens in bits 6-4, ones in bits 3-0, writable, reset zero.
// - minutes tens in bits 6-4, ones in bits 3-0, bit 7 reads zero.
// - hours bit 6 picks format, 1 for 12-hour, 0 for 24-hour.
// - hours bit 5 is the afternoon flag in 12-hour format.
*/
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module rtk_core #(
	parameter logic [rtk_pkg::IDLE_W-1:0] OSC_FAIL_CYC = rtk_pkg::IDLE_W'(rtk_pkg::OSC_FAIL_CYC_DEF)
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire rtk_pkg::rtk_apb_req_t apb_req,
	output rtk_pkg::rtk_apb_rsp_t apb_rsp,
	input wire logic osc_in_pin,
	output logic osc_out_pin,
	output logic osc_out_pin_oe,
	output logic osc_running_flag
);
	import rtk_pkg::*;

	typedef struct packed {
		rtk_time_t tm;
		rtk_bcd_t ctrl;
		rtk_osc_t osc;
		logic [EDGE_W-1:0] edge_cnt;
		logic [IDLE_W-1:0] idle_cnt;
		logic [DIV_W-1:0] div;
		logic osc_prev;
		logic osc_out;
		logic osc_oe;
		rtk_time_t snap;
		logic snap_run;
		logic cap_done;
		logic [DATA_W-1:0] prdata;
		logic last_rd;
		rtk_idx_t last_idx;
	} rtk_state_t;

	localparam rtk_state_t ST_RST = '{
		tm: TIME_RST, ctrl: CTRL_RST, osc: OSC_STOPPED, edge_cnt: '0, idle_cnt: '0,
		div: '0, osc_prev: 1'b0, osc_out: 1'b0, osc_oe: 1'b0, snap: TIME_RST,
		snap_run: 1'b0, cap_done: 1'b0, prdata: '0, last_rd: 1'b0, last_idx: '0
	};

	rtk_state_t st_ff;
	rtk_state_t nxt_st;

	logic src_en;
	logic xtal_mode;
	logic osc_edge;
	logic osc_fail;
	logic sec_tick;
	logic fmt12;
	logic pm;
	logic noon_step;
	logic day_inc;
	rtk_bcd_t hr12;
	rtk_bcd_t date_max;
	rtk_bcd_t sec_n;
	rtk_bcd_t min_n;
	rtk_bcd_t h24_n;
	rtk_bcd_t h12_n;
	rtk_bcd_t wd_n;
	rtk_bcd_t date_n;
	rtk_bcd_t mth_n;
	rtk_bcd_t yr_n;
	logic sec_w;
	logic min_w;
	logic h24_w;
	logic date_w;
	logic mth_w;
	rtk_idx_t idx;
	logic addr_ok;
	logic acc;
	logic wr_acc;
	logic rd_cap;
	logic burst_cont;
	logic refresh;
	rtk_time_t snap_sel;
	logic snap_run_sel;

	// leap test on a two-digit BCD year: value mod 4 equals (2*tens + ones) mod 4
	function automatic logic is_leap(input rtk_bcd_t yr);
		logic [1:0] m;
		m = {yr[4], 1'b0} + yr[1:0];
		is_leap = (m == 2'b00);
	endfunction

	// register view seen by a read; bits not held here read as zero
	function automatic rtk_bcd_t reg_view(input rtk_idx_t i, input rtk_time_t t,
		input logic run, input rtk_bcd_t ctl);
		reg_view = '0;
		case (i)
			IDX_SEC: reg_view = t.sec;
			IDX_MIN: reg_view = t.min & MIN_MASK;
			IDX_HOUR: reg_view = t.hour & HR_WR_MASK;
			IDX_DAY_OF_WEEK:
			begin
				reg_view = t.day_of_week & WKD_WR_MASK;
				reg_view[WKD_RUN_BIT] = run;
			end
			IDX_DATE: reg_view = t.date & DATE_MASK;
			IDX_MONTH:
			begin
				reg_view = t.month & MTH_MASK;
				reg_view[MTH_LEAP_BIT] = is_leap(t.year);
			end
			IDX_YEAR: reg_view = t.year;
			IDX_CTRL: reg_view = ctl;
			default: reg_view = '0;
		endcase
	endfunction

	// source gating: crystal by the start bit, external clock by its enable
	assign xtal_mode = st_ff.tm.sec[SEC_START_BIT] & ~st_ff.ctrl[CTRL_EXT_BIT];
	assign src_en = st_ff.tm.sec[SEC_START_BIT] | st_ff.ctrl[CTRL_EXT_BIT];
	assign osc_edge = osc_in_pin & ~st_ff.osc_prev & src_en;
	assign osc_fail = ~osc_edge & (st_ff.idle_cnt == OSC_FAIL_CYC);
	assign sec_tick = osc_edge & (st_ff.div == DIV_LAST);

	// hour format decode; noon_step is the 11 -> 12 step that flips the afternoon flag
	assign fmt12 = st_ff.tm.hour[HR_FMT_BIT];
	assign pm = st_ff.tm.hour[HR_PM_BIT];
	assign hr12 = st_ff.tm.hour & HR12_MASK;
	assign noon_step = min_w & fmt12 & (hr12 == BCD_11);
	assign day_inc = h24_w | (noon_step & pm);

	// last date of the current month
	always_comb
	begin
		case (st_ff.tm.month & MTH_MASK)
			MTH_FEB: date_max = is_leap(st_ff.tm.year) ? BCD_29 : BCD_28;
			MTH_APR, MTH_JUN, MTH_SEP, MTH_NOV: date_max = BCD_30;
			default: date_max = BCD_31;
		endcase
	end

	// calendar carry chain, seconds up to year
	rtk_bcd_step u_sec (
		.cur(st_ff.tm.sec & SEC_DIGIT_MASK),
		.first(BCD_00),
		.last(BCD_59),
		.inc(sec_tick),
		.nxt(sec_n),
		.wrap(sec_w)
	);

	rtk_bcd_step u_min (
		.cur(st_ff.tm.min & MIN_MASK),
		.first(BCD_00),
		.last(BCD_59),
		.inc(sec_w),
		.nxt(min_n),
		.wrap(min_w)
	);

	rtk_bcd_step u_h24 (
		.cur(st_ff.tm.hour & HR24_MASK),
		.first(BCD_00),
		.last(BCD_23),
		.inc(min_w & ~fmt12),
		.nxt(h24_n),
		.wrap(h24_w)
	);

	// in 12-hour form the 12 -> 01 wrap is no day carry, so its wrap is unused
	rtk_bcd_step u_h12 (
		.cur(hr12),
		.first(BCD_01),
		.last(BCD_12),
		.inc(min_w & fmt12),
		.nxt(h12_n),
		.wrap()
	);

	rtk_bcd_step u_wday (
		.cur(st_ff.tm.day_of_week & WKD_DAY_MASK),
		.first(BCD_01),
		.last(BCD_07),
		.inc(day_inc),
		.nxt(wd_n),
		.wrap()
	);

	rtk_bcd_step u_date (
		.cur(st_ff.tm.date & DATE_MASK),
		.first(BCD_01),
		.last(date_max),
		.inc(day_inc),
		.nxt(date_n),
		.wrap(date_w)
	);

	rtk_bcd_step u_month (
		.cur(st_ff.tm.month & MTH_MASK),
		.first(BCD_01),
		.last(BCD_12),
		.inc(date_w),
		.nxt(mth_n),
		.wrap(mth_w)
	);

	rtk_bcd_step u_year (
		.cur(st_ff.tm.year),
		.first(BCD_00),
		.last(BCD_99),
		.inc(mth_w),
		.nxt(yr_n),
		.wrap()
	);

	// apb decode: in-range aligned index, else slave error
	assign idx = apb_req.paddr[IDX_LSB +: IDX_W];
	assign addr_ok = (apb_req.paddr[IDX_LSB-1:0] == '0) &&
		(apb_req.paddr[PADDR_W-1:IDX_LSB+IDX_W] == '0);
	assign acc = apb_req.psel & apb_req.penable & clk_en &
		(apb_req.pwrite | st_ff.cap_done);
	assign wr_acc = acc & apb_req.pwrite & addr_ok;
	assign rd_cap = apb_req.psel & ~apb_req.pwrite & ~st_ff.cap_done;

	// a read continues the run only when it is the next index and no wrap happened
	assign burst_cont = st_ff.last_rd && (idx == st_ff.last_idx + IDX_ONE) &&
		(st_ff.last_idx != IDX_LAST);
	assign refresh = rd_cap & addr_ok & ~burst_cont;
	assign snap_sel = refresh ? st_ff.tm : st_ff.snap;
	assign snap_run_sel = refresh ? (st_ff.osc == OSC_RUNNING) : st_ff.snap_run;

	// next-state logic for the whole core
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.osc_prev = osc_in_pin;

		// drive the crystal feedback pin only in crystal mode; float it otherwise
		nxt_st.osc_oe = xtal_mode;
		nxt_st.osc_out = xtal_mode & ~osc_in_pin;

		// cycles since the last oscillator edge, saturating at the timeout
		if (osc_edge)
			nxt_st.idle_cnt = '0;
		else if (st_ff.idle_cnt != OSC_FAIL_CYC)
			nxt_st.idle_cnt = st_ff.idle_cnt + IDLE_ONE;

		// oscillator supervision
		case (st_ff.osc)
			OSC_STOPPED:
			begin
				if (osc_edge)
				begin
					nxt_st.osc = OSC_STARTING;
					nxt_st.edge_cnt = EDGE_ONE;
				end
			end
			OSC_STARTING:
			begin
				if (osc_fail)
					nxt_st.osc = OSC_STOPPED;
				else if (osc_edge)
				begin
					nxt_st.edge_cnt = st_ff.edge_cnt + EDGE_ONE;
					if (st_ff.edge_cnt == START_EDGES - EDGE_ONE)
						nxt_st.osc = OSC_RUNNING;
				end
			end
			OSC_RUNNING:
			begin
				if (osc_fail)
					nxt_st.osc = OSC_STOPPED;
			end
			default: nxt_st.osc = OSC_STOPPED;
		endcase

		// second divider counts only enabled source edges; no stop on supply change
		if (osc_edge)
			nxt_st.div = st_ff.div + DIV_ONE;

		// calendar advance
		nxt_st.tm.sec = {st_ff.tm.sec[SEC_START_BIT], sec_n[SEC_START_BIT-1:0]};
		nxt_st.tm.min = min_n;
		if (fmt12)
		begin
			nxt_st.tm.hour = h12_n;
			nxt_st.tm.hour[HR_FMT_BIT] = 1'b1;
			nxt_st.tm.hour[HR_PM_BIT] = pm ^ noon_step;
		end
		else
			nxt_st.tm.hour = h24_n;
		nxt_st.tm.day_of_week = (st_ff.tm.day_of_week & ~WKD_DAY_MASK) | wd_n;
		nxt_st.tm.date = date_n;
		nxt_st.tm.month = mth_n;
		nxt_st.tm.year = yr_n;

		// software writes win over the tick for the register written
		if (wr_acc)
		begin
			case (idx)
				IDX_SEC:
				begin
					nxt_st.tm.sec = apb_req.pwdata[REG_W-1:0] & SEC_WR_MASK;
					nxt_st.div = '0;
				end
				IDX_MIN: nxt_st.tm.min = apb_req.pwdata[REG_W-1:0] & MIN_MASK;
				IDX_HOUR: nxt_st.tm.hour = apb_req.pwdata[REG_W-1:0] & HR_WR_MASK;
				IDX_DAY_OF_WEEK: nxt_st.tm.day_of_week = apb_req.pwdata[REG_W-1:0] & WKD_WR_MASK;
				IDX_DATE: nxt_st.tm.date = apb_req.pwdata[REG_W-1:0] & DATE_MASK;
				IDX_MONTH: nxt_st.tm.month = apb_req.pwdata[REG_W-1:0] & MTH_MASK;
				IDX_YEAR: nxt_st.tm.year = apb_req.pwdata[REG_W-1:0] & YEAR_MASK;
				IDX_CTRL: nxt_st.ctrl = apb_req.pwdata[REG_W-1:0] & CTRL_WR_MASK;
				default: nxt_st.ctrl = st_ff.ctrl;
			endcase
		end

		// read capture: snapshot on a fresh run, data word from the buffer except control, which reads live
		if (rd_cap)
		begin
			nxt_st.cap_done = 1'b1;
			nxt_st.snap = snap_sel;
			nxt_st.snap_run = snap_run_sel;
			nxt_st.prdata = '0;
			if (addr_ok)
			begin
				nxt_st.prdata[REG_W-1:0] = reg_view(idx, snap_sel, snap_run_sel, st_ff.ctrl);
				nxt_st.last_rd = 1'b1;
				nxt_st.last_idx = idx;
			end
		end

		// a write ends a read run, so the next read takes a new snapshot
		if (acc)
		begin
			nxt_st.cap_done = 1'b0;
			if (apb_req.pwrite)
				nxt_st.last_rd = 1'b0;
		end
	end

	// one register for all state; clk_en low freezes everything
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_ff <= ST_RST;
		else if (clk_en)
			st_ff <= nxt_st;
	end

	// outputs: handshake combinational, data from flops
	always_comb
	begin
		apb_rsp.pready = acc;
		apb_rsp.pslverr = acc & ~addr_ok;
		apb_rsp.prdata = st_ff.prdata;
	end

	assign osc_out_pin = st_ff.osc_out;
	assign osc_out_pin_oe = st_ff.osc_oe;
	assign osc_running_flag = (st_ff.osc == OSC_RUNNING);

endmodule
`default_nettype wire

/* test/rtk_osc_model.sv */
/*
  rtk_osc_model: clock source standing at the oscillator input pin, scaled
  to toggle on every pclk so that a second fits the run.
  Assumes the bench owns run; a stopped source holds its last level.
*/
`timescale 1ns/1ps
`default_nettype none

module rtk_osc_model (
	input wire logic clk,
	input wire logic run,
	output logic osc
);
	initial osc = 1'b0;

	// drives only the input pin; the output pin stays unconnected here
	always @(posedge clk)
		if (run)
			osc <= ~osc;
endmodule

`default_nettype wire

/* test/rtk_core_asserts.sv */
/*
  rtk_core_asserts: port-level checks on rtk_core, attached by the bind below.
  Assumes the bench only writes valid bcd values into the time registers.
*/
`timescale 1ns/1ps
`default_nettype none

module rtk_core_asserts #(
	parameter logic [rtk_pkg::IDLE_W-1:0] OSC_FAIL_CYC = 16'h0028
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire rtk_pkg::rtk_apb_req_t apb_req,
	input wire rtk_pkg::rtk_apb_rsp_t apb_rsp,
	input wire logic osc_in_pin,
	input wire logic osc_out_pin,
	input wire logic osc_out_pin_oe,
	input wire logic osc_running_flag
);
	import rtk_pkg::*;
	logic osc_q_ff;
	logic [5:0] edge_cnt_ff;
	logic [16:0] idle_cnt_ff;
	logic rd_ok;

	assign rd_ok = apb_rsp.pready && !apb_req.pwrite && !apb_rsp.pslverr;

	// edges seen while not running, and enabled cycles since the last edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			osc_q_ff <= 1'b0;
			edge_cnt_ff <= '0;
			idle_cnt_ff <= '0;
		end
		else
		begin
			osc_q_ff <= osc_in_pin;
			if (osc_running_flag)
				edge_cnt_ff <= '0;
			else if (osc_in_pin && !osc_q_ff && edge_cnt_ff != 6'h3f)
				edge_cnt_ff <= edge_cnt_ff + 6'h01;
			if (osc_in_pin && !osc_q_ff)
				idle_cnt_ff <= '0;
			else if (clk_en && !idle_cnt_ff[16])
				idle_cnt_ff <= idle_cnt_ff + 17'h00001;
		end
	end

	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence rd_setup;
		apb_req.psel && !apb_req.penable && !apb_req.pwrite && clk_en;
	endsequence
	sequence rd_access;
		apb_req.psel && apb_req.penable && clk_en;
	endsequence

	chk_rd_ready: assert property (rd_setup ##1 rd_access |-> apb_rsp.pready)
		else $error("read not answered in first access cycle");
	chk_wr_ready: assert property (rd_access and apb_req.pwrite |-> apb_rsp.pready)
		else $error("write not answered in first access cycle");
	chk_rd_hold: assert property (!(apb_req.psel && !apb_req.pwrite && clk_en)
		|=> $stable(apb_rsp.prdata))
		else $error("read buffer changed without a read");
	chk_min_bit7: assert property (rd_ok && apb_req.paddr == 8'h04 |-> !apb_rsp.prdata[7])
		else $error("minutes bit 7 read as one");
	chk_sec_digits: assert property (rd_ok && apb_req.paddr == 8'h00
		|-> apb_rsp.prdata[6:4] <= 3'h5 && apb_rsp.prdata[3:0] <= 4'h9)
		else $error("seconds digits out of range");
	chk_day_of_week_range: assert property (rd_ok && apb_req.paddr == 8'h0c
		|-> apb_rsp.prdata[2:0] != 3'h0 && apb_rsp.prdata[7:6] == 2'b00)
		else $error("weekday out of range");
	chk_out_follow: assert property (osc_out_pin_oe && $past(osc_out_pin_oe)
		&& $past(clk_en) |-> osc_out_pin == !$past(osc_in_pin))
		else $error("crystal drive does not follow input");
	chk_out_idle: assert property (!osc_out_pin_oe |-> !osc_out_pin)
		else $error("output pin driven while released");
	chk_run_rise: assert property ($rose(osc_running_flag) |-> edge_cnt_ff >= 6'h1f)
		else $error("running set before 32 oscillator cycles");
	chk_run_drop: assert property (idle_cnt_ff > {1'b0, OSC_FAIL_CYC} + 17'h00004
		|-> !osc_running_flag)
		else $error("running kept after fail timeout");
	chk_run_hold: assert property ($fell(osc_running_flag)
		|-> idle_cnt_ff + 17'h00004 >= {1'b0, OSC_FAIL_CYC})
		else $error("running cleared before fail timeout");
endmodule

bind rtk_core rtk_core_asserts #(
	.OSC_FAIL_CYC(OSC_FAIL_CYC)
) rtk_core_asserts_inst (
	.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .apb_req(apb_req), .apb_rsp(apb_rsp),
	.osc_in_pin(osc_in_pin), .osc_out_pin(osc_out_pin), .osc_out_pin_oe(osc_out_pin_oe),
	.osc_running_flag(osc_running_flag)
);

`default_nettype wire

/* test/rtk_core_tb.sv */
/*
  rtk_core_tb: self-checking bench for rtk_core over apb with a source model.
  Assumes rtk_core_asserts is bound by its own file; fail timeout shortened.
*/
`timescale 1ns/1ps
`default_nettype none

module rtk_core_tb;
	import rtk_pkg::*;
	localparam logic [IDLE_W-1:0] FAIL = 16'h0028;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic clk_en = 1'b1;
	logic jitter = 1'b0;
	logic osc_run = 1'b0;
	logic osc_in_pin;
	logic osc_out_pin;
	logic osc_out_pin_oe;
	logic running;
	rtk_apb_req_t req = '0;
	rtk_apb_rsp_t rsp;
	int err_total = 0;
	int total_checks = 0;
	logic [31:0] q;
	logic e;
	logic [7:0] rst_v [8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h21, 8'h00, 8'h00};
	logic [7:0] roll_v [7] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};

	always #12.5 pclk = ~pclk;

	rtk_core #(.OSC_FAIL_CYC(FAIL)) rtk_core_inst (.pclk(pclk), .presetn(presetn),
		.clk_en(clk_en), .apb_req(req), .apb_rsp(rsp), .osc_in_pin(osc_in_pin),
		.osc_out_pin(osc_out_pin), .osc_out_pin_oe(osc_out_pin_oe),
		.osc_running_flag(running));
	rtk_osc_model rtk_osc_model_inst (.clk(pclk), .run(osc_run), .osc(osc_in_pin));

	// random enable gaps stall the bus; kept off while time is counted
	always @(posedge pclk)
		clk_en <= jitter ? ($urandom % 4 != 0) : 1'b1;

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// one apb transfer; holds the request until pready is seen at an edge
	// no wait limit here: only the watchdog may end a stalled transfer
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge pclk);
		req.penable <= 1'b1;
		@(posedge pclk);
		while (rsp.pready !== 1'b1)
			@(posedge pclk);
		chk("apb answer", 32'h1, {31'h0, rsp.pready});
		q = rsp.prdata;
		e = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] i, input logic [7:0] d);
		bus(1'b1, {1'b0, i, 2'b00}, {24'h0, d});
	endtask

	task automatic rd(input logic [4:0] i, input logic [7:0] x, input string what);
		bus(1'b0, {1'b0, i, 2'b00}, 32'h0);
		chk(what, {24'h0, x}, q);
	endtask

	task automatic wait_run(input logic v, input int lim);
		int n;
		n = 0;
		while (running !== v && n < lim)
		begin
			@(posedge pclk);
			n++;
		end
		chk("running flag", {31'h0, v}, {31'h0, running});
	endtask

	// random packed bcd value with the tens digit up to tmax
	function automatic logic [7:0] rbcd(input int tmax);
		return {4'($urandom % (tmax + 1)), 4'($urandom % 10)};
	endfunction

	// month reads carry the leap flag of the two-digit bcd year
	function automatic logic [7:0] mth(input logic [7:0] m, input logic [7:0] y);
		return m | ((((y[7:4] * 10 + y[3:0]) % 4) == 0) ? 8'h20 : 8'h00);
	endfunction

	// watchdog sized for one counted second plus register traffic
	initial
	begin
		repeat (90000) @(posedge pclk);
		err_total++;
		$display("Error watchdog expected finish seen timeout");
		print_verdict();
	end

	initial
	begin
		logic [7:0] s;
		logic [7:0] m;
		logic [7:0] h;
		void'($urandom(32'hf901f168));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rst_v[i]) rd(5'(i), rst_v[i], "reset value");
		$display("reset values done");
		jitter <= 1'b1;
		repeat (8)
		begin
			s = rbcd(5);
			m = rbcd(5);
			h = {2'b01, 1'($urandom), 1'b0, 4'($urandom % 9 + 1)};
			wr(IDX_SEC, s);
			wr(IDX_MIN, m | 8'h80);
			wr(IDX_HOUR, h);
			rd(IDX_SEC, s, "seconds");
			rd(IDX_MIN, m, "minutes");
			rd(IDX_HOUR, h, "hours");
		end
		rd(5'h10, 8'h00, "unused index");
		bus(1'b1, 8'h81, 32'h0);
		chk("slave error", 32'h1, {31'h0, e});
		jitter <= 1'b0;
		$display("register access done");
		wr(IDX_SEC, 8'h80);
		osc_run <= 1'b1;
		repeat (50) @(posedge pclk);
		chk("running early", 32'h0, {31'h0, running});
		wait_run(1'b1, 40);
		chk("crystal drive", 32'h1, {31'h0, osc_out_pin_oe});
		osc_run <= 1'b0;
		repeat (int'(FAIL) - 4) @(posedge pclk);
		chk("running held", 32'h1, {31'h0, running});
		wait_run(1'b0, 12);
		$display("oscillator start and fail done");
		osc_run <= 1'b1;
		wr(IDX_CTRL, 8'h08);
		wr(IDX_SEC, 8'h00);
		wait_run(1'b1, 100);
		chk("external released", 32'h0, {31'h0, osc_out_pin_oe});
		osc_run <= 1'b0;
		wr(IDX_CTRL, 8'h00);
		wait_run(1'b0, int'(FAIL) + 20);
		osc_run <= 1'b1;
		repeat (100) @(posedge pclk);
		chk("source disabled", 32'h0, {31'h0, running});
		osc_run <= 1'b0;
		$display("external clock done");
		foreach (roll_v[i]) wr(5'(i), roll_v[i]);
		wr(IDX_SEC, 8'hd9);
		osc_run <= 1'b1;
		repeat (65000) @(posedge pclk);
		rd(IDX_SEC, 8'hd9, "before tick");
		// buffer taken before the tick; the wrap back to index 0 must refresh it
		rd(5'h1f, 8'h00, "last index");
		repeat (600) @(posedge pclk);
		rd(IDX_SEC, 8'h80, "seconds wrap");
		rd(IDX_MIN, 8'h00, "minutes wrap");
		rd(IDX_HOUR, 8'h00, "hours wrap");
		rd(IDX_DAY_OF_WEEK, 8'h21, "weekday wrap");
		rd(IDX_DATE, 8'h01, "date wrap");
		rd(IDX_MONTH, mth(8'h01, 8'h00), "month wrap");
		rd(IDX_YEAR, 8'h00, "year wrap");
		$display("calendar rollover done");
		print_verdict();
	end
endmodule

`default_nettype wire
